// ==== logic/sdbcl_legality.sv ====
// Top: command decode, chip-wide states, inter-bank spacing and eight bank trackers
`timescale 1ns/1ps

// Summary of operation
// - Read with auto precharge bank goes idle once tRP follows internal precharge.
// - Write with auto precharge bank goes idle only after tRP is satisfied.
// - Auto refresh holds the chip busy for tRC, then all banks idle.
// - Mode register load holds the chip busy for tMRD, then all idle.
// - Precharge all keeps every bank precharging until tRP, then idle.
// - Read or write state lasts until the burst's final data nibble.
// - Wherever read or write is legal, both auto precharge variants are legal.
// - Pin decode of ACTIVE, READ, WRITE and PRECHARGE.
// - Deselect and NOP continue; terminator disable accepted in any state.
// - With bank n idle, bank m takes whatever its own state allows.
// - Busy bank n does not block ACTIVE/READ/WRITE/PRECHARGE to bank m; READ/WRITE still wait out auto precharge spacing.
// - Legality applies only with clock enable high on two edges.
// - Row active only after tRCD with no burst or register access.
// - Read auto precharge begins at the earliest legal explicit precharge point; the code starts it HALF clocks after READ, before PRECHARGE is legal.
// - Write auto precharge begins when write recovery after last data ends.
// - Other banks stay usable during auto precharge; bus contention still avoided.
// - Auto precharge address bit picks one or all banks for precharge.
module sdbcl_legality #(
  parameter int T_RCD = sdbcl_pkg::DEF_T_RCD,
  parameter int T_RP = sdbcl_pkg::DEF_T_RP,
  parameter int T_RC = sdbcl_pkg::DEF_T_RC,
  parameter int T_MRD = sdbcl_pkg::DEF_T_MRD,
  parameter int T_WR = sdbcl_pkg::DEF_T_WR,
  parameter int BURST_LENGTH = sdbcl_pkg::DEF_BURST_LENGTH,
  parameter int READ_LATENCY_ROUNDED_UP = sdbcl_pkg::DEF_READ_LATENCY,
  parameter int WRITE_LATENCY = sdbcl_pkg::DEF_WRITE_LATENCY
) (
  input logic mclk,
  input logic rst_n,
  input logic cke,
  input logic cs_n,
  input logic ras_n,
  input logic cas_n,
  input logic we_n,
  input logic bank_select_bit0,
  input logic bank_select_bit1,
  input logic bank_select_bit2,
  input logic auto_precharge_address_bit,
  output logic [23:0] bank_state,
  output logic all_banks_idle,
  output logic chip_busy,
  output logic cmd_illegal
);

  // ==================================================================
  // Derived counts
  localparam int HALF = BURST_LENGTH / 2;
  localparam logic [7:0] L_RC = 8'(T_RC);
  localparam logic [7:0] L_MRD = 8'(T_MRD);
  localparam logic [7:0] L_RP = 8'(T_RP);
  localparam logic [7:0] WAP_RD = 8'(WRITE_LATENCY + HALF + T_WR);
  localparam logic [7:0] WAP_WR = 8'(HALF);
  localparam logic [7:0] RAP_RD = 8'(HALF);
  localparam logic [7:0] RAP_WR = 8'(READ_LATENCY_ROUNDED_UP + HALF + 1 - WRITE_LATENCY);

  // ==================================================================
  // Parameter checks
  if (BURST_LENGTH != 4 && BURST_LENGTH != 8) begin : g_bad_bl
    $error("burst length must be 4 or 8");
  end
  if (T_RCD < 1 || T_RP < 1 || T_RC < 1 || T_MRD < 1 || T_WR < 1) begin : g_bad_t
    $error("every timing count must be at least one clock");
  end
  if (WAP_RD + T_RP > 250 || T_RC > 250 || READ_LATENCY_ROUNDED_UP > 200) begin : g_bad_w
    $error("timing counts exceed the 8-bit timers");
  end
  if (READ_LATENCY_ROUNDED_UP + HALF + 1 <= WRITE_LATENCY) begin : g_bad_l
    $error("write latency too large for read to write spacing");
  end

  typedef struct packed {
    sdbcl_pkg::sdbcl_chip_e st;
    logic [7:0] tmr;
    logic cke_prev;
    logic [7:0] wap_cnt;
    logic [7:0] rap_cnt;
    logic illegal;
    logic all_idle;
    logic busy;
    logic [7:0] dwell;
  } sdbcl_top_s;

  sdbcl_top_s q;
  sdbcl_top_s d;

  sdbcl_pkg::sdbcl_cmd_e cmd;
  logic [3:0] pins;
  logic [2:0] bank_idx;
  logic cke_ok;
  logic exec;
  logic preall;
  logic bad;
  logic go;
  logic force_pre;
  logic [7:0] sel;
  logic [7:0] bank_legal;
  logic [7:0] idle_vec;
  logic [7:0] preok_vec;
  logic [7:0] prech_vec;
  logic all_now;
  logic pre_ok_all;

  assign pins = {cs_n, ras_n, cas_n, we_n};
  assign bank_idx = {bank_select_bit2, bank_select_bit1, bank_select_bit0};
  assign cke_ok = q.cke_prev && cke;
  assign preall = auto_precharge_address_bit;
  assign all_now = &idle_vec;
  assign pre_ok_all = &preok_vec;

  // Outputs straight from flops
  assign all_banks_idle = q.all_idle;
  assign chip_busy = q.busy;
  assign cmd_illegal = q.illegal;

  // ==================================================================
  // Command decode; without clock enable on two edges nothing is judged
  always_comb begin
    cmd = sdbcl_pkg::CMD_NOP;
    if (!cke_ok) begin
      cmd = sdbcl_pkg::CMD_NOP;
    end else if (cs_n) begin
      // A low chip select with this pattern is a READ; chip select high with it is a terminator disable, anything else deselect
      cmd = (pins[2:0] == sdbcl_pkg::PIN_DTD) ? sdbcl_pkg::CMD_DTD : sdbcl_pkg::CMD_DESEL;
    end else begin
      case (pins)
        sdbcl_pkg::PIN_NOP: cmd = sdbcl_pkg::CMD_NOP;
        sdbcl_pkg::PIN_ACT: cmd = sdbcl_pkg::CMD_ACT;
        sdbcl_pkg::PIN_READ: cmd = sdbcl_pkg::CMD_READ;
        sdbcl_pkg::PIN_WRITE: cmd = sdbcl_pkg::CMD_WRITE;
        sdbcl_pkg::PIN_PRE: cmd = sdbcl_pkg::CMD_PRE;
        sdbcl_pkg::PIN_REF: cmd = sdbcl_pkg::CMD_REF;
        sdbcl_pkg::PIN_LMR: cmd = sdbcl_pkg::CMD_LMR;
        default: cmd = sdbcl_pkg::CMD_NOP;
      endcase
    end
  end

  // ==================================================================
  // Legality verdict and the strobes handed to the banks
  always_comb begin
    exec = (cmd != sdbcl_pkg::CMD_DESEL) && (cmd != sdbcl_pkg::CMD_NOP) &&
           (cmd != sdbcl_pkg::CMD_DTD);
    bad = 1'b0;
    if (exec && q.st != sdbcl_pkg::CH_NORMAL) begin
      bad = 1'b1;
    end else begin
      case (cmd)
        sdbcl_pkg::CMD_REF, sdbcl_pkg::CMD_LMR: begin
          bad = !all_now;
        end
        sdbcl_pkg::CMD_PRE: begin
          bad = preall ? !pre_ok_all : !bank_legal[bank_idx];
        end
        sdbcl_pkg::CMD_ACT: begin
          bad = !bank_legal[bank_idx];
        end
        sdbcl_pkg::CMD_READ: begin
          bad = !bank_legal[bank_idx] || (q.wap_cnt < WAP_RD) ||
                (q.rap_cnt < RAP_RD);
        end
        sdbcl_pkg::CMD_WRITE: begin
          bad = !bank_legal[bank_idx] || (q.wap_cnt < WAP_WR) ||
                (q.rap_cnt < RAP_WR);
        end
        default: bad = 1'b0;
      endcase
    end
    // Illegal commands are flagged and dropped, so state stays coherent
    go = exec && !bad;
    force_pre = go && (cmd == sdbcl_pkg::CMD_PRE) && preall;
    sel = 8'h00;
    if (cmd == sdbcl_pkg::CMD_ACT || cmd == sdbcl_pkg::CMD_READ ||
        cmd == sdbcl_pkg::CMD_WRITE || (cmd == sdbcl_pkg::CMD_PRE && !preall)) begin
      sel[bank_idx] = 1'b1;
    end
  end

  // ==================================================================
  // Chip-wide state, spacing counters and status flags
  always_comb begin
    d = q;
    d.cke_prev = cke;
    if (q.st != sdbcl_pkg::CH_NORMAL) begin
      if (q.tmr > sdbcl_pkg::CNT_ONE) begin
        d.tmr = q.tmr - sdbcl_pkg::CNT_ONE;
      end else begin
        d.st = sdbcl_pkg::CH_NORMAL;
      end
    end
    if (go) begin
      case (cmd)
        sdbcl_pkg::CMD_REF: begin
          d.st = sdbcl_pkg::CH_REFRESH;
          d.tmr = L_RC;
        end
        sdbcl_pkg::CMD_LMR: begin
          d.st = sdbcl_pkg::CH_MODE;
          d.tmr = L_MRD;
        end
        sdbcl_pkg::CMD_PRE: begin
          if (preall) begin
            d.st = sdbcl_pkg::CH_PREALL;
            d.tmr = L_RP;
          end
        end
        default: ;
      endcase
    end
    // Cycles since the last auto precharge access, saturating so old ones fade
    if (q.wap_cnt != sdbcl_pkg::CNT_SAT) begin
      d.wap_cnt = q.wap_cnt + sdbcl_pkg::CNT_ONE;
    end
    if (q.rap_cnt != sdbcl_pkg::CNT_SAT) begin
      d.rap_cnt = q.rap_cnt + sdbcl_pkg::CNT_ONE;
    end
    if (go && cmd == sdbcl_pkg::CMD_WRITE && auto_precharge_address_bit) begin
      d.wap_cnt = sdbcl_pkg::CNT_ONE;
    end
    if (go && cmd == sdbcl_pkg::CMD_READ && auto_precharge_address_bit) begin
      d.rap_cnt = sdbcl_pkg::CNT_ONE;
    end
    if (d.st != q.st) begin
      d.dwell = sdbcl_pkg::CNT_ONE;
    end else if (q.dwell != sdbcl_pkg::CNT_SAT) begin
      d.dwell = q.dwell + sdbcl_pkg::CNT_ONE;
    end
    d.illegal = exec && bad;
    // Judged on the next chip state so a starting refresh never reports idle
    d.all_idle = all_now && (d.st == sdbcl_pkg::CH_NORMAL);
    d.busy = (d.st != sdbcl_pkg::CH_NORMAL);
  end

  // State register; clock enable is taken as high out of reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q.st <= sdbcl_pkg::CH_NORMAL;
      q.tmr <= 8'h00;
      q.cke_prev <= 1'b1;
      q.wap_cnt <= 8'hFF;
      q.rap_cnt <= 8'hFF;
      q.illegal <= 1'b0;
      q.all_idle <= 1'b1;
      q.busy <= 1'b0;
      q.dwell <= 8'h01;
    end else begin
      q <= d;
    end
  end

  // ==================================================================
  // Eight independent bank trackers
  for (genvar i = 0; i < sdbcl_pkg::NUM_BANKS; i++) begin : g_bank
    logic [2:0] st;

    sdbcl_bank #(
      .T_RCD(T_RCD),
      .T_RP(T_RP),
      .T_WR(T_WR),
      .BURST_LENGTH(BURST_LENGTH),
      .READ_LATENCY_ROUNDED_UP(READ_LATENCY_ROUNDED_UP),
      .WRITE_LATENCY(WRITE_LATENCY)
    ) u_bank (
      .mclk(mclk),
      .rst_n(rst_n),
      .cmd(cmd),
      .sel(sel[i]),
      .go(go),
      .ap(auto_precharge_address_bit),
      .force_pre(force_pre),
      .state(st),
      .legal(bank_legal[i])
    );

    assign bank_state[i*3 +: 3] = st;
    assign idle_vec[i] = (st == sdbcl_pkg::BK_IDLE);
    assign prech_vec[i] = (st == sdbcl_pkg::BK_PRECH);
    // Bursts, activations and auto precharge cannot be cut short by a group precharge
    assign preok_vec[i] = (st == sdbcl_pkg::BK_IDLE) || (st == sdbcl_pkg::BK_ACTIVE) ||
                          (st == sdbcl_pkg::BK_PRECH);
  end

  // ==================================================================
  // Checks
  default clocking top_cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  nop_clean_a: assert property (
    (cmd == sdbcl_pkg::CMD_DESEL || cmd == sdbcl_pkg::CMD_NOP || cmd == sdbcl_pkg::CMD_DTD)
      |=> !cmd_illegal)
    else $error("idle command was flagged");

  cke_gate_a: assert property (
    !(cke && q.cke_prev) |=> !cmd_illegal && $stable(chip_busy))
    else $error("command judged without clock enable");

  busy_block_a: assert property (
    (exec && chip_busy) |=> cmd_illegal ##1 !$rose(chip_busy))
    else $error("command during chip busy not refused");

  chipwide_a: assert property (
    ((cmd == sdbcl_pkg::CMD_REF || cmd == sdbcl_pkg::CMD_LMR) && !all_now) |=>
      cmd_illegal && !chip_busy)
    else $error("chip command with busy bank accepted");

  refresh_len_a: assert property (
    (q.st == sdbcl_pkg::CH_REFRESH && d.st == sdbcl_pkg::CH_NORMAL) |-> q.dwell == L_RC)
    else $error("refresh period differs from tRC");

  mode_len_a: assert property (
    (q.st == sdbcl_pkg::CH_MODE && d.st == sdbcl_pkg::CH_NORMAL) |-> q.dwell == L_MRD)
    else $error("mode access period differs from tMRD");

  preall_len_a: assert property (
    force_pre |=> (&prech_vec) && chip_busy)
    else $error("precharge all did not reach every bank");

  preall_end_a: assert property (
    (q.st == sdbcl_pkg::CH_PREALL && d.st == sdbcl_pkg::CH_NORMAL) |-> q.dwell == L_RP)
    else $error("precharge all period differs from tRP");

  wap_gap_a: assert property (
    (cmd == sdbcl_pkg::CMD_READ && q.wap_cnt < WAP_RD) |=> cmd_illegal)
    else $error("read too soon after write with auto precharge");

  rap_gap_a: assert property (
    (cmd == sdbcl_pkg::CMD_WRITE && q.rap_cnt < RAP_WR) |=> cmd_illegal)
    else $error("write too soon after read with auto precharge");

endmodule : sdbcl_legality

// ==== logic/sdbcl_pkg.sv ====
// Package: commands, bank and chip states, and timing defaults of the legality tracker
package sdbcl_pkg;

  // ==================================================================
  // Sizes
  localparam int NUM_BANKS = 8;
  localparam int BANK_W = 3;
  localparam int TMR_W = 8;
  localparam logic [7:0] CNT_SAT = 8'hFF;
  localparam logic [7:0] CNT_ONE = 8'h01;

  // ==================================================================
  // Timing defaults, in command clocks
  localparam int DEF_T_RCD = 6;
  localparam int DEF_T_RP = 6;
  localparam int DEF_T_RC = 22;
  localparam int DEF_T_MRD = 4;
  localparam int DEF_T_WR = 6;
  localparam int DEF_BURST_LENGTH = 4;
  localparam int DEF_READ_LATENCY = 7;
  localparam int DEF_WRITE_LATENCY = 3;

  // ==================================================================
  // Pin patterns {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] PIN_NOP = 4'h7;
  localparam logic [3:0] PIN_ACT = 4'h3;
  localparam logic [3:0] PIN_READ = 4'h5;
  localparam logic [3:0] PIN_WRITE = 4'h4;
  localparam logic [3:0] PIN_PRE = 4'h2;
  localparam logic [3:0] PIN_REF = 4'h1;
  localparam logic [3:0] PIN_LMR = 4'h0;
  localparam logic [2:0] PIN_DTD = 3'h5;

  // ==================================================================
  // Decoded commands
  typedef enum logic [3:0] {
    CMD_DESEL = 4'h0,
    CMD_NOP = 4'h1,
    CMD_DTD = 4'h2,
    CMD_ACT = 4'h3,
    CMD_READ = 4'h4,
    CMD_WRITE = 4'h5,
    CMD_PRE = 4'h6,
    CMD_REF = 4'h7,
    CMD_LMR = 4'h8
  } sdbcl_cmd_e;

  // Per-bank states
  typedef enum logic [2:0] {
    BK_IDLE = 3'h0,
    BK_ACTG = 3'h1,
    BK_ACTIVE = 3'h2,
    BK_READ = 3'h3,
    BK_WRITE = 3'h4,
    BK_READ_AP = 3'h5,
    BK_WRITE_AP = 3'h6,
    BK_PRECH = 3'h7
  } sdbcl_bank_e;

  // Chip-wide states
  typedef enum logic [1:0] {
    CH_NORMAL = 2'h0,
    CH_REFRESH = 2'h1,
    CH_MODE = 2'h2,
    CH_PREALL = 2'h3
  } sdbcl_chip_e;

endpackage : sdbcl_pkg

// ==== logic/sdbcl_bank.sv ====
// One bank: state machine, countdown timer and same-bank command check
`timescale 1ns/1ps
module sdbcl_bank #(
  parameter int T_RCD = sdbcl_pkg::DEF_T_RCD,
  parameter int T_RP = sdbcl_pkg::DEF_T_RP,
  parameter int T_WR = sdbcl_pkg::DEF_T_WR,
  parameter int BURST_LENGTH = sdbcl_pkg::DEF_BURST_LENGTH,
  parameter int READ_LATENCY_ROUNDED_UP = sdbcl_pkg::DEF_READ_LATENCY,
  parameter int WRITE_LATENCY = sdbcl_pkg::DEF_WRITE_LATENCY
) (
  input logic mclk,
  input logic rst_n,
  input sdbcl_pkg::sdbcl_cmd_e cmd,
  input logic sel,
  input logic go,
  input logic ap,
  input logic force_pre,
  output logic [2:0] state,
  output logic legal
);

  localparam int HALF = BURST_LENGTH / 2;
  localparam logic [7:0] L_RCD = 8'(T_RCD);
  localparam logic [7:0] L_RP = 8'(T_RP);
  localparam logic [7:0] L_RD = 8'(READ_LATENCY_ROUNDED_UP + HALF);
  localparam logic [7:0] L_WR = 8'(WRITE_LATENCY + HALF);
  localparam logic [7:0] L_RDAP = 8'(HALF);
  localparam logic [7:0] L_WRAP = 8'(WRITE_LATENCY + HALF + T_WR);

  typedef struct packed {
    sdbcl_pkg::sdbcl_bank_e st;
    logic [7:0] tmr;
    logic ap_pre;
    logic [7:0] dwell;
  } sdbcl_bank_s;

  sdbcl_bank_s q;
  sdbcl_bank_s d;

  assign state = q.st;

  // ==================================================================
  // Next state; a command to this bank wins over its own timer
  always_comb begin
    d = q;
    legal = 1'b0;
    case (q.st)
      sdbcl_pkg::BK_IDLE: legal = (cmd == sdbcl_pkg::CMD_ACT) || (cmd == sdbcl_pkg::CMD_PRE);
      sdbcl_pkg::BK_ACTIVE: legal = (cmd != sdbcl_pkg::CMD_ACT);
      sdbcl_pkg::BK_READ: legal = (cmd == sdbcl_pkg::CMD_READ); // No write mid read burst
      sdbcl_pkg::BK_WRITE: legal = (cmd == sdbcl_pkg::CMD_READ) || (cmd == sdbcl_pkg::CMD_WRITE);
      default: legal = 1'b0;
    endcase
    if (q.tmr > sdbcl_pkg::CNT_ONE) begin
      d.tmr = q.tmr - sdbcl_pkg::CNT_ONE;
    end
    case (q.st)
      sdbcl_pkg::BK_ACTG, sdbcl_pkg::BK_READ, sdbcl_pkg::BK_WRITE: begin
        if (q.tmr <= sdbcl_pkg::CNT_ONE) d.st = sdbcl_pkg::BK_ACTIVE;
      end
      sdbcl_pkg::BK_PRECH: begin
        if (q.tmr <= sdbcl_pkg::CNT_ONE) d.st = sdbcl_pkg::BK_IDLE;
      end
      sdbcl_pkg::BK_READ_AP, sdbcl_pkg::BK_WRITE_AP: begin
        if (q.tmr <= sdbcl_pkg::CNT_ONE && q.ap_pre) begin
          d.st = sdbcl_pkg::BK_IDLE;
          d.ap_pre = 1'b0;
        end else if (q.tmr <= sdbcl_pkg::CNT_ONE) begin
          d.ap_pre = 1'b1;
          d.tmr = L_RP;
        end
      end
      default: ;
    endcase
    if (force_pre) begin
      d.st = sdbcl_pkg::BK_PRECH;
      d.tmr = L_RP;
      d.ap_pre = 1'b0;
    end else if (go && sel) begin
      d.ap_pre = 1'b0;
      case (cmd)
        sdbcl_pkg::CMD_ACT: begin
          d.st = sdbcl_pkg::BK_ACTG;
          d.tmr = L_RCD;
        end
        sdbcl_pkg::CMD_READ: begin
          d.st = ap ? sdbcl_pkg::BK_READ_AP : sdbcl_pkg::BK_READ;
          d.tmr = ap ? L_RDAP : L_RD;
        end
        sdbcl_pkg::CMD_WRITE: begin
          d.st = ap ? sdbcl_pkg::BK_WRITE_AP : sdbcl_pkg::BK_WRITE;
          d.tmr = ap ? L_WRAP : L_WR;
        end
        sdbcl_pkg::CMD_PRE: begin
          if (q.st != sdbcl_pkg::BK_IDLE) begin
            d.st = sdbcl_pkg::BK_PRECH;
            d.tmr = L_RP;
          end
        end
        default: ;
      endcase
    end
    // Dwell counts cycles spent in the state, restarted by any new entry
    if (d.st != q.st || force_pre || (go && sel)) begin
      d.dwell = sdbcl_pkg::CNT_ONE;
    end else if (q.dwell != sdbcl_pkg::CNT_SAT) begin
      d.dwell = q.dwell + sdbcl_pkg::CNT_ONE;
    end
  end

  // State register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{st: sdbcl_pkg::BK_IDLE, tmr: 8'h00, ap_pre: 1'b0, dwell: 8'h01};
    end else begin
      q <= d;
    end
  end

  // ==================================================================
  // Checks
  default clocking bk_cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  act_start_a: assert property (
    (go && sel && cmd == sdbcl_pkg::CMD_ACT && !force_pre) |=> q.st == sdbcl_pkg::BK_ACTG)
    else $error("bank did not start activating");
  actg_time_a: assert property (
    (q.st == sdbcl_pkg::BK_ACTG && d.st == sdbcl_pkg::BK_ACTIVE) |-> q.dwell == L_RCD)
    else $error("activating period differs from tRCD");
  burst_end_a: assert property (
    (q.st == sdbcl_pkg::BK_READ && d.st == sdbcl_pkg::BK_ACTIVE) |-> q.dwell == L_RD)
    else $error("read state did not end at last nibble");
  rdap_time_a: assert property (
    (q.st == sdbcl_pkg::BK_READ_AP && d.st == sdbcl_pkg::BK_IDLE) |-> q.dwell == L_RDAP + L_RP)
    else $error("read auto precharge length wrong");
  wrap_time_a: assert property (
    (q.st == sdbcl_pkg::BK_WRITE_AP && d.st == sdbcl_pkg::BK_IDLE) |-> q.dwell == L_WRAP + L_RP)
    else $error("write auto precharge length wrong");

endmodule : sdbcl_bank

// ==== tb/sdbcl_ctrl_model.sv ====
// Controller model: drives the command pins one command at a time
`timescale 1ns/1ps
module sdbcl_ctrl_model (
  input logic mclk,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic bank_select_bit0,
  output logic bank_select_bit1,
  output logic bank_select_bit2,
  output logic auto_precharge_address_bit
);
  // ==================================================================
  // Idle pins: NOP with clock enable high until set_cke changes it
  initial begin
    cke = 1'b1;
    {cs_n, ras_n, cas_n, we_n} = sdbcl_pkg::PIN_NOP;
    {bank_select_bit2, bank_select_bit1, bank_select_bit0} = 3'h0;
    auto_precharge_address_bit = 1'b0;
  end

  // One command after a rising edge; the bench orders traffic legally unless it
  // wants a refusal
  task automatic issue(input logic [3:0] pins, input logic [2:0] bank, input logic ap,
                       input logic last);
    @(posedge mclk);
    {cs_n, ras_n, cas_n, we_n} <= pins;
    {bank_select_bit2, bank_select_bit1, bank_select_bit0} <= bank;
    auto_precharge_address_bit <= ap;
    if (last) begin
      @(posedge mclk);
      {cs_n, ras_n, cas_n, we_n} <= sdbcl_pkg::PIN_NOP;
      // Released address lines flip so a stale value never looks valid
      {bank_select_bit2, bank_select_bit1, bank_select_bit0} <= ~bank;
      auto_precharge_address_bit <= ~ap;
    end
  endtask : issue

  // Clock enable change just after a rising edge
  task automatic set_cke(input logic v);
    @(posedge mclk);
    cke <= v;
  endtask : set_cke
endmodule : sdbcl_ctrl_model

// ==== tb/sdbcl_bank_command_legality_tb.sv ====
// Testbench: bank state timing, refusals and inter-bank spacing
`timescale 1ns/1ps
module sdbcl_bank_command_legality_tb;
  // Short distinct timings so a swapped timer shows up
  localparam int TRCD = 3;
  localparam int TRP = 5;
  localparam int TRC = 9;
  localparam int TMRD = 2;
  localparam int TWR = 4;
  localparam int BL = 4;
  localparam int RL = 7;
  localparam int WL = 3;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic cke, cs_n, ras_n, cas_n, we_n, ba0, ba1, ba2, apb;
  logic [23:0] bank_state;
  logic all_banks_idle, chip_busy, cmd_illegal;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;

  // ==================================================================
  // Clock, device and controller
  always #10 mclk = ~mclk;
  sdbcl_legality #(.T_RCD(TRCD), .T_RP(TRP), .T_RC(TRC), .T_MRD(TMRD), .T_WR(TWR),
    .BURST_LENGTH(BL), .READ_LATENCY_ROUNDED_UP(RL), .WRITE_LATENCY(WL)) uut (
    .mclk(mclk), .rst_n(rst_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .bank_select_bit0(ba0), .bank_select_bit1(ba1), .bank_select_bit2(ba2),
    .auto_precharge_address_bit(apb), .bank_state(bank_state),
    .all_banks_idle(all_banks_idle), .chip_busy(chip_busy), .cmd_illegal(cmd_illegal));
  sdbcl_ctrl_model ctrl (.mclk(mclk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .bank_select_bit0(ba0), .bank_select_bit1(ba1), .bank_select_bit2(ba2),
    .auto_precharge_address_bit(apb));

  // ==================================================================
  // Shared checks
  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("BAD t=%0t %s", $time, m);
    end
  endtask : chk

  function automatic logic on(input int b, input logic [2:0] s);
    on = (b == 8) ? (chip_busy === 1'b1) : (bank_state[3*b+:3] === s);
  endfunction : on

  // Time how many cycles bank b (8 = chip busy) stays in state s
  task automatic span(input int b, input logic [2:0] s, input int n);
    int k;
    k = 0;
    #1;
    repeat (4) if (!on(b, s)) begin @(posedge mclk); #1; end
    while (on(b, s) && k < 300) begin k++; @(posedge mclk); #1; end
    chk(k == n, $sformatf("bank %0d state %0d lasted %0d", b, s, k));
  endtask : span

  // One command, then the refusal flag one cycle later
  task automatic try_cmd(input logic [3:0] p, input logic [2:0] b, input logic ap,
                         input logic ex);
    ctrl.issue(p, b, ap, 1'b1);
    #1;
    chk(cmd_illegal === ex, "refusal flag");
  endtask : try_cmd

  task automatic t_auto_pre;
    try_cmd(sdbcl_pkg::PIN_ACT, 3'h0, 1'b0, 1'b0);
    span(0, 3'h1, TRCD);
    try_cmd(sdbcl_pkg::PIN_READ, 3'h0, 1'b1, 1'b0);
    span(0, 3'h5, BL / 2 + TRP);
    try_cmd(sdbcl_pkg::PIN_ACT, 3'h1, 1'b0, 1'b0);
    span(1, 3'h1, TRCD);
    try_cmd(sdbcl_pkg::PIN_WRITE, 3'h1, 1'b1, 1'b0);
    span(1, 3'h6, WL + BL / 2 + TWR + TRP);
    $display("test auto precharge done");
  endtask : t_auto_pre

  task automatic t_burst;
    try_cmd(sdbcl_pkg::PIN_ACT, 3'h2, 1'b0, 1'b0);
    span(2, 3'h1, TRCD);
    try_cmd(sdbcl_pkg::PIN_READ, 3'h2, 1'b0, 1'b0);
    span(2, 3'h3, RL + BL / 2);
    chk(bank_state[8:6] === 3'h2, "active after read");
    try_cmd(sdbcl_pkg::PIN_WRITE, 3'h2, 1'b0, 1'b0);
    span(2, 3'h4, WL + BL / 2);
    try_cmd(sdbcl_pkg::PIN_PRE, 3'h2, 1'b0, 1'b0);
    span(2, 3'h7, TRP);
    $display("test burst done");
  endtask : t_burst

  task automatic t_chip;
    try_cmd(sdbcl_pkg::PIN_REF, 3'h0, 1'b0, 1'b0);
    chk(all_banks_idle === 1'b0, "idle during refresh");
    try_cmd(sdbcl_pkg::PIN_ACT, 3'h3, 1'b0, 1'b1);
    // Two refresh cycles are already spent on the refused command
    span(8, 3'h0, TRC - 2);
    #1;
    chk(all_banks_idle === 1'b1, "idle after refresh");
    try_cmd(sdbcl_pkg::PIN_LMR, 3'h0, 1'b0, 1'b0);
    span(8, 3'h0, TMRD);
    try_cmd(sdbcl_pkg::PIN_ACT, 3'h3, 1'b0, 1'b0);
    span(3, 3'h1, TRCD);
    try_cmd(sdbcl_pkg::PIN_PRE, 3'h6, 1'b1, 1'b0);
    chk(bank_state === {8{3'h7}}, "all precharging");
    span(8, 3'h0, TRP);
    $display("test chip wide done");
  endtask : t_chip

  task automatic t_refuse;
    try_cmd(sdbcl_pkg::PIN_READ, 3'h4, 1'b0, 1'b1);
    try_cmd(4'hD, 3'h4, 1'b0, 1'b0);
    try_cmd(sdbcl_pkg::PIN_NOP, 3'h4, 1'b0, 1'b0);
    try_cmd(4'hF, 3'h4, 1'b0, 1'b0);
    try_cmd(sdbcl_pkg::PIN_ACT, 3'h4, 1'b0, 1'b0);
    try_cmd(sdbcl_pkg::PIN_ACT, 3'h5, 1'b0, 1'b0);
    try_cmd(sdbcl_pkg::PIN_ACT, 3'h6, 1'b0, 1'b0);
    try_cmd(sdbcl_pkg::PIN_REF, 3'h0, 1'b0, 1'b1);
    try_cmd(sdbcl_pkg::PIN_LMR, 3'h0, 1'b0, 1'b1);
    try_cmd(sdbcl_pkg::PIN_ACT, 3'h4, 1'b0, 1'b1);
    repeat (8) @(posedge mclk);
    $display("test refusals done");
  endtask : t_refuse

  // Commands sampled with clock enable low are ignored, then judged again
  task automatic t_cke;
    ctrl.set_cke(1'b0);
    try_cmd(sdbcl_pkg::PIN_READ, 3'h7, 1'b0, 1'b0);
    ctrl.set_cke(1'b1);
    try_cmd(sdbcl_pkg::PIN_READ, 3'h7, 1'b0, 1'b1);
    $display("test clock enable done");
  endtask : t_cke

  task automatic t_space;
    ctrl.issue(sdbcl_pkg::PIN_READ, 3'h4, 1'b1, 1'b0);
    try_cmd(sdbcl_pkg::PIN_READ, 3'h5, 1'b0, 1'b1);
    try_cmd(sdbcl_pkg::PIN_WRITE, 3'h6, 1'b0, 1'b1);
    repeat (12) @(posedge mclk);
    ctrl.issue(sdbcl_pkg::PIN_READ, 3'h5, 1'b1, 1'b0);
    ctrl.issue(sdbcl_pkg::PIN_NOP, 3'h0, 1'b0, 1'b0);
    try_cmd(sdbcl_pkg::PIN_READ, 3'h6, 1'b0, 1'b0);
    chk(bank_state[20:18] === 3'h3, "read accepted");
    try_cmd(sdbcl_pkg::PIN_PRE, 3'h0, 1'b1, 1'b1);
    repeat (12) @(posedge mclk);
    try_cmd(sdbcl_pkg::PIN_ACT, 3'h5, 1'b0, 1'b0);
    repeat (4) @(posedge mclk);
    ctrl.issue(sdbcl_pkg::PIN_WRITE, 3'h6, 1'b1, 1'b0);
    try_cmd(sdbcl_pkg::PIN_ACT, 3'h4, 1'b0, 1'b0);
    try_cmd(sdbcl_pkg::PIN_READ, 3'h5, 1'b0, 1'b1);
    $display("test spacing done");
  endtask : t_space

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  // Hang guard, well beyond the fewer than two hundred cycles the tests need
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      $display("BAD t=%0t timeout", $time);
      tally_and_finish();
    end
  end

  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    t_auto_pre();
    t_burst();
    t_chip();
    t_refuse();
    t_cke();
    t_space();
    tally_and_finish();
  end
endmodule : sdbcl_bank_command_legality_tb
